// ---- vcore_fault_supervisor_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module vcore_fault_supervisor_tb;
   import vfs_pkg::*;
   localparam logic [MV_W-1:0] TC = CODE_REF_MV;
   localparam logic [MV_W-1:0] TG = CODE_REF_MV + CODE_STEP_MV * 13'h002C;
   localparam logic [MV_W-1:0] BON = BIAS_ON_MV + 13'h0010;
   logic clk_sys, rstn, en, slewing, die_hot, die_cool, hsel, hwrite, hready;
   logic cgood, ggood, hot_n, alert, irq, hreadyout, hresp;
   logic [7:0] ccode, gcode;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [MV_W-1:0] thr [8];
   vfs_sense_s sense;
   vfs_phase_s cmd, phase;
   vfs_gate_s gate;
   int n_mismatch, num_checks, cyc;
   assign hready = hreadyout;
   vfs_top uut (.clk_sys(clk_sys), .rstn(rstn), .regulator_enable(en), .cpu_voltage_code(ccode),
      .gpu_voltage_code(gcode), .slewing(slewing), .die_hot(die_hot), .die_cool(die_cool),
      .sense(sense), .phase(phase), .gate(gate), .cpu_output_good(cgood), .gpu_output_good(ggood),
      .over_temp_flag_oen(hot_n), .alert(alert), .irq(irq), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
   vfs_stage_model fets (.clk_sys(clk_sys), .rstn(rstn), .gate(gate), .cmd(cmd), .phase(phase));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      do @(posedge clk_sys); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rdv = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, rdv);
   endtask : rd
   task automatic cyc_en;
      en <= 1'b0;
      wt(3);
      chk("cgood_off", 32'h0, 32'(cgood));
      chk("ggood_off", 32'h0, 32'(ggood));
      en <= 1'b1;
      wt(6);
   endtask : cyc_en
   task automatic good(input logic exp, input string nm);
      $display("test %s done", nm);
      chk("cgood", 32'(exp), 32'(cgood));
   endtask : good
   ////////////////////////////////////////////////////////////
   // Cycle limit and cross conduction watch
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      chk("overlap", 32'h0, 32'(gate.high_gate & gate.low_side_gate_out));
      if (cyc == 6000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      thr = '{TZ0_MV, TZ1_MV, TZ2_MV, TZ3_MV, TZ4_MV, TZ5_MV, TZ_ALERT_MV, TZ_HOT_MV};
      sense = '{cpu_out:TC, gpu_out:TG, drv_bias:BON, five_bias:BON, three_bias:BON,
         cpu_therm:12'h3E8, gpu_therm:12'h3E8};
      {rstn, en, slewing, die_hot, die_cool, hsel, hwrite, htrans, hsize} = 12'h002;
      {haddr, hwdata, cmd} = '0;
      {ccode, gcode} = 16'hD3FF;
      wt(2);
      rstn <= 1'b1;
      wt(1);
      rd(A_TZONE, 32'h0, "tzone");
      rd(A_STATUS, 32'h14, "status");
      rd(8'h40, 32'h0, "unmapped");
      rd(A_MASK, 32'h0, "mask");
      en <= 1'b1;
      wt(6);
      chk("ggood", 32'h1, 32'(ggood));
      rd(A_STATUS, 32'h27, "status");
      rd(A_TARGET, {3'h0, TG, 3'h0, TC}, "target");
      ccode <= 8'hD4;
      wt(4);
      rd(A_TARGET, {3'h0, TG, 3'h0, TC + CODE_STEP_MV}, "target");
      ccode <= 8'hD3;
      sense.cpu_out <= TC + PG_HI_MV - 12'h001;
      wt(4);
      good(1'b1, "upper");
      sense.cpu_out <= TC - PG_LO_MV + 12'h001;
      wt(4);
      good(1'b1, "lower");
      slewing <= 1'b1;
      sense.cpu_out <= TC - 12'h200;
      wt(4);
      good(1'b1, "slew");
      slewing <= 1'b0;
      sense.cpu_out <= TC;
      wt(4);
      good(1'b1, "slew_end");
      cmd.current_limit <= 2'b01;
      cmd.pwm <= 2'b11;
      wt(8);
      chk("high", 32'h2, 32'(gate.high_gate));
      cmd.current_limit <= 2'b00;
      wt(8);
      chk("high", 32'h3, 32'(gate.high_gate));
      cmd.pwm <= 2'b00;
      cmd.ext_pwm3 <= 1'b1;
      cmd.ext_gpu <= 1'b1;
      wt(8);
      chk("low", 32'h3, 32'(gate.low_side_gate_out));
      chk("ext", 32'h3, 32'({gate.ext_pwm3, gate.ext_gpu}));
      cmd.zero_cross <= 2'b11;
      wt(4);
      chk("low", 32'h0, 32'(gate.low_side_gate_out));
      cmd.zero_cross <= 2'b00;
      bus(1'b1, A_IRQ, 32'h3F);
      for (int i = 0; i < 8; i++) begin
         sense.cpu_therm <= thr[i] - 12'h001;
         wt(4);
         rd(A_TZONE, 32'((9'h002 << i) - 9'h001), "tzone");
         chk("alert", 32'(i > 5), 32'(alert));
         chk("hot_n", 32'(i < 7), 32'(hot_n));
      end
      chk("irq", 32'h0, 32'(irq));
      rd(A_IRQ, 32'h1 << IB_HOT, "irq_status");
      bus(1'b1, A_MASK, 32'h1 << IB_HOT);
      wt(2);
      chk("irq", 32'h1, 32'(irq));
      sense.cpu_therm <= TZ_SHUT_MV - 12'h001;
      wt(4);
      good(1'b0, "therm_shut");
      chk("gates", 32'h0, 32'({gate.high_gate, gate.low_side_gate_out}));
      sense.cpu_therm <= 12'h3E8;
      bus(1'b1, A_MASK, 32'h0);
      bus(1'b1, A_IRQ, 32'h3F);
      rd(A_IRQ, 32'h0, "irq_clear");
      cyc_en();
      good(1'b1, "restart");
      sense.cpu_out <= TC + PG_HI_MV + 12'h001;
      wt(4);
      chk("clamp", 32'h7, 32'({gate.high_gate, gate.low_side_gate_out, gate.ext_clamp}));
      sense.cpu_out <= TC;
      wt(4);
      good(1'b0, "ov_latch");
      rd(A_IRQ, 32'h1 << IB_OV, "irq_status");
      bus(1'b1, A_IRQ, 32'h3F);
      cyc_en();
      slewing <= 1'b1;
      sense.cpu_out <= FIXED_OV_MV + 12'h001;
      wt(4);
      chk("clamp", 32'h7, 32'({gate.high_gate, gate.low_side_gate_out, gate.ext_clamp}));
      good(1'b0, "fixed_ov");
      slewing <= 1'b0;
      sense.cpu_out <= TC;
      cyc_en();
      sense.cpu_out <= TC - PG_LO_MV - 12'h001;
      wt(4);
      chk("gates", 32'h0, 32'({gate.high_gate, gate.low_side_gate_out}));
      sense.cpu_out <= TC;
      wt(4);
      good(1'b0, "uv_latch");
      cyc_en();
      sense.five_bias <= BIAS_ON_MV - 12'h001;
      wt(4);
      good(1'b1, "bias_hyst");
      sense.five_bias <= BIAS_ON_MV - BIAS_HYST_MV - 12'h001;
      wt(3);
      chk("ggood", 32'h0, 32'(ggood));
      sense.five_bias <= BIAS_ON_MV - 12'h001;
      cyc_en();
      good(1'b0, "bias_hold");
      sense.five_bias <= BON;
      cyc_en();
      good(1'b1, "bias_back");
      die_hot <= 1'b1;
      die_cool <= 1'b0;
      wt(4);
      good(1'b0, "die_hot");
      die_hot <= 1'b0;
      cyc_en();
      good(1'b0, "die_warm");
      die_cool <= 1'b1;
      cyc_en();
      good(1'b1, "die_cool");
      wrap_up();
   end
endmodule : vcore_fault_supervisor_tb
`default_nettype wire

// ---- vfs_pkg.sv ----
package vfs_pkg;
   // Voltages in millivolts, 13-bit unsigned samples from the monitor ADCs
   localparam int MV_W = 13;
   localparam logic [MV_W-1:0] CODE_STEP_MV = 13'h0005;
   localparam logic [7:0] CODE_REF = 8'hD3;
   localparam logic [MV_W-1:0] CODE_REF_MV = 13'h0514;
   localparam logic [MV_W-1:0] BIAS_ON_MV = 13'h1130;
   localparam logic [MV_W-1:0] BIAS_HYST_MV = 13'h00C8;
   localparam logic [MV_W-1:0] PG_HI_MV = 13'h00DC;
   localparam logic [MV_W-1:0] PG_LO_MV = 13'h013B;
   localparam logic [MV_W-1:0] FIXED_OV_MV = 13'h06A4;
   localparam logic [MV_W-1:0] TZ0_MV = 13'h030F;
   localparam logic [MV_W-1:0] TZ1_MV = 13'h02A8;
   localparam logic [MV_W-1:0] TZ2_MV = 13'h027E;
   localparam logic [MV_W-1:0] TZ3_MV = 13'h0256;
   localparam logic [MV_W-1:0] TZ4_MV = 13'h022F;
   localparam logic [MV_W-1:0] TZ5_MV = 13'h020B;
   localparam logic [MV_W-1:0] TZ_ALERT_MV = 13'h01CA;
   localparam logic [MV_W-1:0] TZ_HOT_MV = 13'h01C7;
   localparam logic [MV_W-1:0] TZ_SHUT_MV = 13'h019A;
   // Register byte addresses
   localparam logic [7:0] A_TZONE = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_IRQ = 8'h08;
   localparam logic [7:0] A_MASK = 8'h0C;
   localparam logic [7:0] A_CTRL = 8'h10;
   localparam logic [7:0] A_TARGET = 8'h14;
   // Interrupt bits
   localparam int IRQ_W = 6;
   localparam int IB_UV = 0;
   localparam int IB_OV = 1;
   localparam int IB_FOV = 2;
   localparam int IB_HOT = 3;
   localparam int IB_TSD = 4;
   localparam int IB_BIAS = 5;
   localparam int NPH = 2;
   typedef enum logic [3:0] {
      VFS_OFF = 4'b0001,
      VFS_RUN = 4'b0010,
      VFS_DEAD = 4'b0100,
      VFS_CLAMP = 4'b1000
   } vfs_st_e;
   typedef enum logic [2:0] {
      GD_IDLE = 3'b001,
      GD_HIGH = 3'b010,
      GD_LOW = 3'b100
   } vfs_gd_e;
   typedef struct packed {
      logic [MV_W-1:0] cpu_out;
      logic [MV_W-1:0] gpu_out;
      logic [MV_W-1:0] drv_bias;
      logic [MV_W-1:0] five_bias;
      logic [MV_W-1:0] three_bias;
      logic [MV_W-1:0] cpu_therm;
      logic [MV_W-1:0] gpu_therm;
   } vfs_sense_s;
   typedef struct packed {
      logic [NPH-1:0] pwm;
      logic [NPH-1:0] low_side_sense;
      logic [NPH-1:0] switch_node_sense;
      logic [NPH-1:0] zero_cross;
      logic [NPH-1:0] current_limit;
      logic ext_pwm3;
      logic ext_gpu;
      logic ext_lim3;
      logic ext_lim_gpu;
   } vfs_phase_s;
   typedef struct packed {
      logic [NPH-1:0] high_gate;
      logic [NPH-1:0] low_side_gate_out;
      logic ext_pwm3;
      logic ext_gpu;
      logic ext_clamp;
   } vfs_gate_s;
endpackage : vfs_pkg

// ---- vfs_stage_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module vfs_stage_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire vfs_pkg::vfs_gate_s gate,
   input wire vfs_pkg::vfs_phase_s cmd,
   output vfs_pkg::vfs_phase_s phase
);
   import vfs_pkg::*;
   logic [2*NPH-1:0] d1_q;
   logic [2*NPH-1:0] d2_q;
   ////////////////////////////////////////////////////////////
   // Gate charge delay of two cycles seen at the sense pins
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         d1_q <= '0;
         d2_q <= '0;
      end else begin
         d1_q <= {gate.high_gate, gate.low_side_gate_out};
         d2_q <= d1_q;
      end
   end
   ////////////////////////////////////////////////////////////
   // Bench commands pass, sense pins follow the FETs
   always_comb begin
      phase = cmd;
      phase.low_side_sense = d2_q[NPH-1:0];
      phase.switch_node_sense = d2_q[2*NPH-1:NPH];
   end
endmodule : vfs_stage_model
`default_nettype wire

// ---- vfs_top.sv ----
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module vfs_top (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic regulator_enable,
   input wire logic [7:0] cpu_voltage_code,
   input wire logic [7:0] gpu_voltage_code,
   input wire logic slewing,
   input wire logic die_hot,
   input wire logic die_cool,
   input wire vfs_pkg::vfs_sense_s sense,
   input wire vfs_pkg::vfs_phase_s phase,
   output vfs_pkg::vfs_gate_s gate,
   output logic cpu_output_good,
   output logic gpu_output_good,
   output logic over_temp_flag_oen,
   output logic alert,
   output logic irq,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   import vfs_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      vfs_st_e st;
      vfs_gd_e [NPH-1:0] gd;
      logic en_q;
      logic bias_ok;
      logic die_lock;
      logic [MV_W-1:0] cpu_tgt;
      logic [MV_W-1:0] gpu_tgt;
      logic [7:0] tzone;
      logic [IRQ_W-1:0] stat;
      logic [IRQ_W-1:0] mask;
      logic ext_gate;
      logic wr_pend;
      logic [7:0] wr_addr;
      vfs_gate_s gate;
      logic cgood;
      logic ggood;
      logic hot_oen;
      logic alert;
      logic irq;
      logic [31:0] rdata;
   } vfs_state_s;
   vfs_state_s s_q, s_d;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [MV_W-1:0] code_mv(input logic [7:0] c);
      logic [MV_W-1:0] d;
      d = MV_W'(c) - MV_W'(CODE_REF);
      code_mv = CODE_REF_MV + MV_W'(d * CODE_STEP_MV);
   endfunction : code_mv
   function automatic logic in_win(input logic [MV_W-1:0] v, input logic [MV_W-1:0] t);
      in_win = (v <= t + PG_HI_MV) && (v + PG_LO_MV >= t);
   endfunction : in_win
   logic [MV_W-1:0] therm_min;
   logic bias_lo, bias_hi, cpu_uv, gpu_uv, trk_ov, fix_ov, therm_sd, en_fall, en_rise;
   logic bus_rd, bus_wr;
   always_comb begin
      therm_min = (sense.cpu_therm < sense.gpu_therm) ? sense.cpu_therm : sense.gpu_therm;
      bias_hi = (sense.drv_bias > BIAS_ON_MV) && (sense.five_bias > BIAS_ON_MV)
         && (sense.three_bias > BIAS_ON_MV);
      bias_lo = (sense.drv_bias < BIAS_ON_MV - BIAS_HYST_MV) || (sense.five_bias < BIAS_ON_MV - BIAS_HYST_MV)
         || (sense.three_bias < BIAS_ON_MV - BIAS_HYST_MV);
      cpu_uv = (sense.cpu_out + PG_LO_MV < s_q.cpu_tgt);
      gpu_uv = (sense.gpu_out + PG_LO_MV < s_q.gpu_tgt);
      trk_ov = !slewing && ((sense.cpu_out > s_q.cpu_tgt + PG_HI_MV)
         || (sense.gpu_out > s_q.gpu_tgt + PG_HI_MV));
      fix_ov = (sense.cpu_out > FIXED_OV_MV) || (sense.gpu_out > FIXED_OV_MV);
      therm_sd = therm_min < TZ_SHUT_MV;
      en_fall = s_q.en_q && !regulator_enable;
      en_rise = !s_q.en_q && regulator_enable;
      bus_rd = hsel && hready && htrans[1] && !hwrite;
      bus_wr = hsel && hready && htrans[1] && hwrite;
   end
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      s_d.en_q = regulator_enable;
      s_d.cpu_tgt = code_mv(cpu_voltage_code);
      s_d.gpu_tgt = code_mv(gpu_voltage_code);
      if (bias_hi) begin
         s_d.bias_ok = 1'b1;
      end else if (bias_lo) begin
         s_d.bias_ok = 1'b0;
      end
      if (die_hot) begin
         s_d.die_lock = 1'b1;
      end else if (die_cool && en_rise) begin
         s_d.die_lock = 1'b0;
      end
      // Thermal zone byte
      s_d.tzone = {therm_min < TZ_HOT_MV, therm_min < TZ_ALERT_MV, therm_min < TZ5_MV,
         therm_min < TZ4_MV, therm_min < TZ3_MV, therm_min < TZ2_MV,
         therm_min < TZ1_MV, therm_min < TZ0_MV};
      s_d.hot_oen = !(therm_min < TZ_HOT_MV);
      s_d.alert = therm_min < TZ_ALERT_MV;
      // Sequencer
      case (s_q.st)
         VFS_OFF: begin
            if (regulator_enable && s_q.bias_ok && !s_q.die_lock && !therm_sd) begin
               s_d.st = VFS_RUN;
            end
         end
         VFS_RUN: begin
            if (!regulator_enable || !s_q.bias_ok) begin
               s_d.st = VFS_OFF;
            end else if (fix_ov || trk_ov) begin
               s_d.st = VFS_CLAMP;
            end else if ((!slewing && (cpu_uv || gpu_uv)) || therm_sd || die_hot) begin
               s_d.st = VFS_DEAD;
            end
         end
         VFS_DEAD: begin
            if (fix_ov) begin
               s_d.st = VFS_CLAMP;
            end else if (en_fall) begin
               s_d.st = VFS_OFF;
            end
         end
         VFS_CLAMP: begin
            if (en_fall) begin
               s_d.st = VFS_OFF;
            end
         end
         default: s_d.st = VFS_OFF;
      endcase
      if (s_q.st != VFS_CLAMP && s_q.st != VFS_DEAD && fix_ov) begin
         s_d.st = VFS_CLAMP;
      end
      // Power good, masked while slewing
      if (s_q.st != VFS_RUN || !regulator_enable || bias_lo) begin
         s_d.cgood = 1'b0;
         s_d.ggood = 1'b0;
      end else if (!slewing) begin
         s_d.cgood = in_win(sense.cpu_out, s_q.cpu_tgt);
         s_d.ggood = in_win(sense.gpu_out, s_q.gpu_tgt);
      end
      // Internal gate drivers with break-before-make
      for (int i = 0; i < NPH; i++) begin
         s_d.gate.high_gate[i] = 1'b0;
         s_d.gate.low_side_gate_out[i] = 1'b0;
         case (s_q.gd[i])
            GD_IDLE: begin
               if (phase.pwm[i] && !phase.current_limit[i] && !phase.low_side_sense[i]) begin
                  s_d.gd[i] = GD_HIGH;
               end else if (!phase.pwm[i] && !phase.switch_node_sense[i] && !phase.zero_cross[i]) begin
                  s_d.gd[i] = GD_LOW;
               end
            end
            GD_HIGH: begin
               if (!phase.pwm[i]) begin
                  s_d.gd[i] = GD_IDLE;
               end
            end
            GD_LOW: begin
               if (phase.pwm[i] || phase.zero_cross[i]) begin
                  s_d.gd[i] = GD_IDLE;
               end
            end
            default: s_d.gd[i] = GD_IDLE;
         endcase
         if (s_q.st != VFS_RUN || s_d.st != VFS_RUN) begin
            s_d.gd[i] = GD_IDLE;
         end
         s_d.gate.high_gate[i] = (s_d.gd[i] == GD_HIGH) && !s_q.ext_gate;
         s_d.gate.low_side_gate_out[i] = s_q.ext_gate ? (s_d.gd[i] == GD_HIGH) : (s_d.gd[i] == GD_LOW);
         if (s_d.st == VFS_CLAMP) begin
            s_d.gate.high_gate[i] = 1'b0;
            s_d.gate.low_side_gate_out[i] = !s_q.ext_gate;
         end
      end
      s_d.gate.ext_pwm3 = (s_d.st == VFS_RUN) && phase.ext_pwm3 && !phase.ext_lim3;
      s_d.gate.ext_gpu = (s_d.st == VFS_RUN) && phase.ext_gpu && !phase.ext_lim_gpu;
      s_d.gate.ext_clamp = s_d.st == VFS_CLAMP;
      // Sticky interrupt status, set wins over clear
      s_d.wr_pend = bus_wr;
      s_d.wr_addr = haddr[7:0];
      if (s_q.wr_pend) begin
         if (s_q.wr_addr == A_IRQ) begin
            s_d.stat = s_q.stat & ~hwdata[IRQ_W-1:0];
         end else if (s_q.wr_addr == A_MASK) begin
            s_d.mask = hwdata[IRQ_W-1:0];
         end else if (s_q.wr_addr == A_CTRL) begin
            s_d.ext_gate = hwdata[0];
         end
      end
      s_d.stat[IB_UV] = s_d.stat[IB_UV] | (s_q.st == VFS_RUN && s_d.st == VFS_DEAD);
      s_d.stat[IB_OV] = s_d.stat[IB_OV] | (trk_ov && s_q.st == VFS_RUN);
      s_d.stat[IB_FOV] = s_d.stat[IB_FOV] | fix_ov;
      s_d.stat[IB_HOT] = s_d.stat[IB_HOT] | (!s_d.hot_oen && s_q.hot_oen);
      s_d.stat[IB_TSD] = s_d.stat[IB_TSD] | die_hot | therm_sd;
      s_d.stat[IB_BIAS] = s_d.stat[IB_BIAS] | (s_q.bias_ok && bias_lo);
      s_d.irq = |(s_d.stat & s_d.mask);
      // Read data for the next data phase
      s_d.rdata = 32'h0000_0000;
      if (bus_rd) begin
         if (haddr[7:0] == A_TZONE) begin
            s_d.rdata = {24'h00_0000, s_q.tzone};
         end else if (haddr[7:0] == A_STATUS) begin
            s_d.rdata = {24'h00_0000, s_q.st, 1'b0, s_q.bias_ok, s_q.cgood, s_q.ggood};
         end else if (haddr[7:0] == A_IRQ) begin
            s_d.rdata = {26'h000_0000, s_q.stat};
         end else if (haddr[7:0] == A_MASK) begin
            s_d.rdata = {26'h000_0000, s_q.mask};
         end else if (haddr[7:0] == A_CTRL) begin
            s_d.rdata = {31'h0000_0000, s_q.ext_gate};
         end else if (haddr[7:0] == A_TARGET) begin
            s_d.rdata = {3'h0, s_q.gpu_tgt, 3'h0, s_q.cpu_tgt};
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.st <= VFS_OFF;
         s_q.gd <= {NPH{GD_IDLE}};
         s_q.hot_oen <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
   assign gate = s_q.gate;
   assign cpu_output_good = s_q.cgood;
   assign gpu_output_good = s_q.ggood;
   assign over_temp_flag_oen = s_q.hot_oen;
   assign alert = s_q.alert;
   assign irq = s_q.irq;
   assign hrdata = s_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   property p_enable_low;
      @(posedge clk_sys) disable iff (!rstn) !regulator_enable |=> !cpu_output_good && !gpu_output_good;
   endproperty
   a_enable_low: assert property (p_enable_low) else $error("good high with enable low");
   property p_fixed_ov;
      @(posedge clk_sys) disable iff (!rstn) fix_ov |=> s_q.st == VFS_CLAMP ##1 !cpu_output_good;
   endproperty
   a_fixed_ov: assert property (p_fixed_ov) else $error("fixed overvoltage not clamped");
   property p_clamp_latch;
      @(posedge clk_sys) disable iff (!rstn) s_q.st == VFS_CLAMP && !en_fall |=> s_q.st == VFS_CLAMP;
   endproperty
   a_clamp_latch: assert property (p_clamp_latch) else $error("clamp released early");
   property p_dead_off;
      @(posedge clk_sys) disable iff (!rstn) s_q.st == VFS_DEAD |-> gate.high_gate == '0;
   endproperty
   a_dead_off: assert property (p_dead_off) else $error("high gate on after fault");
   property p_bbm;
      @(posedge clk_sys) disable iff (!rstn) !(gate.high_gate[0] && gate.low_side_gate_out[0] && !s_q.ext_gate);
   endproperty
   a_bbm: assert property (p_bbm) else $error("both FETs on");
   property p_limit;
      @(posedge clk_sys) disable iff (!rstn)
         phase.current_limit[0] && s_q.gd[0] == GD_IDLE |=> s_q.gd[0] != GD_HIGH;
   endproperty
   a_limit: assert property (p_limit) else $error("pulse during current limit");
   property p_hot;
      @(posedge clk_sys) disable iff (!rstn) therm_min < TZ_HOT_MV |=> !over_temp_flag_oen && s_q.tzone[7];
   endproperty
   a_hot: assert property (p_hot) else $error("hot flag missing");
   property p_alert;
      @(posedge clk_sys) disable iff (!rstn) therm_min >= TZ_ALERT_MV |=> !alert && !s_q.tzone[6];
   endproperty
   a_alert: assert property (p_alert) else $error("alert without cause");
   property p_code;
      @(posedge clk_sys) disable iff (!rstn) gpu_voltage_code == 8'hFF |=> s_q.gpu_tgt == 13'h05F0;
   endproperty
   a_code: assert property (p_code) else $error("code FF not 1.520 V");
   property p_start;
      @(posedge clk_sys) disable iff (!rstn) s_q.st == VFS_OFF && !s_q.bias_ok |=> s_q.st == VFS_OFF;
   endproperty
   a_start: assert property (p_start) else $error("start without bias");
endmodule : vfs_top
`default_nettype wire
